// ==== rtl/obd_pkg.sv ====
// holds offsets, field positions, reset values and pin presets of the bank d settings
// assumes byte-wide registers behind the device's serial register port
package obd_pkg;

  // register offsets
  localparam logic [7:0] OBD_ADDR_INT_RATIO = 8'h28;
  localparam logic [7:0] OBD_ADDR_FRAC_LO = 8'h29;
  localparam logic [7:0] OBD_ADDR_FRAC_MID = 8'h2a;
  localparam logic [7:0] OBD_ADDR_FRAC_HI = 8'h2b;
  localparam logic [7:0] OBD_ADDR_FRAC_INT = 8'h2c;
  localparam logic [7:0] OBD_ADDR_DIV_CTRL = 8'h2d;
  localparam logic [7:0] OBD_ADDR_BANK_CTRL = 8'h2e;
  localparam logic [7:0] OBD_ADDR_OUT0_CTRL = 8'h30;
  localparam logic [7:0] OBD_ADDR_OUT1_CTRL = 8'h31;
  localparam logic [7:0] OBD_ADDR_SYNC = 8'h3d;

  // field positions
  localparam int OBD_POS_POST_DIV = 0;
  localparam int OBD_POS_DIV_TYPE = 4;
  localparam int OBD_POS_SRC_SEL = 5;
  localparam int OBD_POS_BANK_PD = 7;
  localparam int OBD_POS_CFG_SRC = 0;
  localparam int OBD_POS_OUT_PD = 7;
  localparam int OBD_POS_STYLE = 2;
  localparam int OBD_POS_SWING = 0;
  localparam int OBD_POS_SYNC = 7;

  // reset values
  localparam logic [5:0] OBD_RST_INT_RATIO = 6'h0d;
  localparam logic [23:0] OBD_RST_FRAC = 24'h600000;
  localparam logic [3:0] OBD_RST_FRAC_INT = 4'h9;
  localparam logic [1:0] OBD_RST_POST_DIV = 2'h0;
  localparam logic [1:0] OBD_RST_SWING = 2'h0;

  // legal integer part of the fractional ratio
  localparam logic [3:0] OBD_FRAC_INT_MIN = 4'h5;
  localparam logic [3:0] OBD_FRAC_INT_MAX = 4'hf;

  // swing codes and their single-ended swing in millivolts
  localparam logic [1:0] OBD_SWING_350 = 2'h0;
  localparam logic [1:0] OBD_SWING_500 = 2'h1;
  localparam logic [1:0] OBD_SWING_750 = 2'h2;
  localparam logic [9:0] OBD_MV_350 = 10'h15e;
  localparam logic [9:0] OBD_MV_500 = 10'h1f4;
  localparam logic [9:0] OBD_MV_750 = 10'h2ee;

  // post-divider codes and their division factors
  localparam logic [1:0] OBD_POST_DIV1 = 2'h0;
  localparam logic [1:0] OBD_POST_DIV2 = 2'h1;
  localparam logic [1:0] OBD_POST_DIV4 = 2'h2;

  // integer ratio codes chosen by the two bank control pins
  localparam logic [5:0] OBD_PIN_RATIO_0 = 6'h0d;
  localparam logic [5:0] OBD_PIN_RATIO_1 = 6'h09;
  localparam logic [5:0] OBD_PIN_RATIO_2 = 6'h10;
  localparam logic [5:0] OBD_PIN_RATIO_3 = 6'h19;

  // output style encoding
  localparam logic OBD_STYLE_LVDS = 1'b0;
  localparam logic OBD_STYLE_LVPECL = 1'b1;

endpackage

// ==== rtl/obd_pin_sync.sv ====
// holds a three-stage synchroniser for asynchronous control pins
// assumes pins change slowly compared with clk_sys
`timescale 1ns/100ps
module obd_pin_sync
  import obd_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_level
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] level_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("obd_pin_sync needs at least one pin");
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift chain; only the second stage reads the first
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else begin
      stage1_q <= pin_async;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= '0;
    end else if (stage2_q == stage3_q) begin
      level_q <= stage3_q;
    end
  end

  assign pin_level = level_q;

endmodule

// ==== rtl/obd_config_regs.sv ====
// holds the bank d configuration registers and the settings they drive
// assumes a serial-interface front end presents byte writes and reads on clk_sys
// Function
// - post-divider code 00/01/10 divides 1/2/4
// - divider-type bit picks integer or fractional divider
// - source bit zero drives bank from divider
// - bank power-down stops bank, second output floats
// - config-source bit picks pins or registers
// - output power-down stops first, floats second output
// - style bit zero LVDS, one LVPECL
// - swing codes give 350, 500, 750 mV
// - fractional ratio is integer part plus fraction
`timescale 1ns/100ps
module obd_config_regs
  import obd_pkg::*;
#(
  parameter int PIN_WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic [PIN_WIDTH-1:0] bank_ctl_pins,
  output logic [5:0] integer_divider_ratio,
  output logic [23:0] fraction_word,
  output logic [3:0] fraction_integer_part,
  output logic [2:0] post_divide_factor,
  output logic [27:0] fractional_ratio,
  output logic fractional_ratio_valid,
  output logic fractional_path_selected,
  output logic bank_driven_by_divider,
  output logic bank_active,
  output logic first_bank_output_on,
  output logic second_bank_output_oe,
  output logic output_style_lvpecl,
  output logic [9:0] output_swing_mv,
  output logic settings_from_registers,
  output logic divider_sync_pulse
);

  if (PIN_WIDTH != 2) begin : g_bad_pins
    $error("obd_config_regs serves exactly two bank control pins");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // division factor of a post-divider code, zero when reserved
  function automatic logic [2:0] post_factor(input logic [1:0] code);
    case (code)
      OBD_POST_DIV1: post_factor = 3'h1;
      OBD_POST_DIV2: post_factor = 3'h2;
      OBD_POST_DIV4: post_factor = 3'h4;
      default: post_factor = 3'h0;
    endcase
  endfunction

  // swing in millivolts of a swing code, zero when reserved
  function automatic logic [9:0] swing_mv(input logic [1:0] code);
    case (code)
      OBD_SWING_350: swing_mv = OBD_MV_350;
      OBD_SWING_500: swing_mv = OBD_MV_500;
      OBD_SWING_750: swing_mv = OBD_MV_750;
      default: swing_mv = 10'h000;
    endcase
  endfunction

  // integer ratio code chosen by the pins
  function automatic logic [5:0] pin_ratio(input logic [1:0] pins);
    case (pins)
      2'h0: pin_ratio = OBD_PIN_RATIO_0;
      2'h1: pin_ratio = OBD_PIN_RATIO_1;
      2'h2: pin_ratio = OBD_PIN_RATIO_2;
      default: pin_ratio = OBD_PIN_RATIO_3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // stored fields

  logic [5:0] int_ratio_q;
  logic [23:0] frac_q;
  logic [3:0] frac_int_q;
  logic [1:0] post_div_q;
  logic div_type_q;
  logic src_sel_q;
  logic bank_pd_q;
  logic cfg_src_q;
  logic out_pd_q;
  logic style_q;
  logic [1:0] swing_q;
  logic [PIN_WIDTH-1:0] pins_level;
  logic wr_int;
  logic wr_frac_lo;
  logic wr_frac_mid;
  logic wr_frac_hi;
  logic wr_frac_int;
  logic wr_div_ctrl;
  logic wr_bank_ctrl;
  logic wr_out0;
  logic wr_sync;

  // address decode of writes
  assign wr_int = reg_wr_en && (reg_addr == OBD_ADDR_INT_RATIO);
  assign wr_frac_lo = reg_wr_en && (reg_addr == OBD_ADDR_FRAC_LO);
  assign wr_frac_mid = reg_wr_en && (reg_addr == OBD_ADDR_FRAC_MID);
  assign wr_frac_hi = reg_wr_en && (reg_addr == OBD_ADDR_FRAC_HI);
  assign wr_frac_int = reg_wr_en && (reg_addr == OBD_ADDR_FRAC_INT);
  assign wr_div_ctrl = reg_wr_en && (reg_addr == OBD_ADDR_DIV_CTRL);
  assign wr_bank_ctrl = reg_wr_en && (reg_addr == OBD_ADDR_BANK_CTRL);
  assign wr_out0 = reg_wr_en &&
                   ((reg_addr == OBD_ADDR_OUT0_CTRL) || (reg_addr == OBD_ADDR_OUT1_CTRL));
  assign wr_sync = reg_wr_en && (reg_addr == OBD_ADDR_SYNC);

  // divider ratio and fraction registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_ratio_q <= OBD_RST_INT_RATIO;
      frac_q <= OBD_RST_FRAC;
      frac_int_q <= OBD_RST_FRAC_INT;
    end else begin
      if (wr_int) begin
        int_ratio_q <= reg_wdata[5:0];
      end
      if (wr_frac_lo) begin
        frac_q[7:0] <= reg_wdata;
      end
      if (wr_frac_mid) begin
        frac_q[15:8] <= reg_wdata;
      end
      if (wr_frac_hi) begin
        frac_q[23:16] <= reg_wdata;
      end
      if (wr_frac_int) begin
        frac_int_q <= reg_wdata[3:0];
      end
    end
  end

  // divider control: post-divider, divider type and source select
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      post_div_q <= OBD_RST_POST_DIV;
      div_type_q <= 1'b0;
      src_sel_q <= 1'b0;
    end else if (wr_div_ctrl) begin
      post_div_q <= reg_wdata[OBD_POS_POST_DIV +: 2];
      div_type_q <= reg_wdata[OBD_POS_DIV_TYPE];
      src_sel_q <= reg_wdata[OBD_POS_SRC_SEL];
    end
  end

  // bank control: bank power-down and configuration source
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bank_pd_q <= 1'b0;
      cfg_src_q <= 1'b0;
    end else if (wr_bank_ctrl) begin
      bank_pd_q <= reg_wdata[OBD_POS_BANK_PD];
      cfg_src_q <= reg_wdata[OBD_POS_CFG_SRC];
    end
  end

  // output control; both output words share the one power-down bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_pd_q <= 1'b0;
      style_q <= OBD_STYLE_LVDS;
      swing_q <= OBD_RST_SWING;
    end else if (wr_out0) begin
      out_pd_q <= reg_wdata[OBD_POS_OUT_PD];
      if (reg_addr == OBD_ADDR_OUT0_CTRL) begin
        style_q <= reg_wdata[OBD_POS_STYLE];
        swing_q <= reg_wdata[OBD_POS_SWING +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads; reserved bits and unmapped offsets read zero

  logic [7:0] rdata_d;

  // read mux
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      OBD_ADDR_INT_RATIO: rdata_d[5:0] = int_ratio_q;
      OBD_ADDR_FRAC_LO: rdata_d = frac_q[7:0];
      OBD_ADDR_FRAC_MID: rdata_d = frac_q[15:8];
      OBD_ADDR_FRAC_HI: rdata_d = frac_q[23:16];
      OBD_ADDR_FRAC_INT: rdata_d[3:0] = frac_int_q;
      OBD_ADDR_DIV_CTRL: begin
        rdata_d[OBD_POS_POST_DIV +: 2] = post_div_q;
        rdata_d[OBD_POS_DIV_TYPE] = div_type_q;
        rdata_d[OBD_POS_SRC_SEL] = src_sel_q;
      end
      OBD_ADDR_BANK_CTRL: begin
        rdata_d[OBD_POS_BANK_PD] = bank_pd_q;
        rdata_d[OBD_POS_CFG_SRC] = cfg_src_q;
      end
      OBD_ADDR_OUT0_CTRL: begin
        rdata_d[OBD_POS_OUT_PD] = out_pd_q;
        rdata_d[OBD_POS_STYLE] = style_q;
        rdata_d[OBD_POS_SWING +: 2] = swing_q;
      end
      OBD_ADDR_OUT1_CTRL: rdata_d[OBD_POS_OUT_PD] = out_pd_q;
      default: rdata_d = 8'h00; // the sync trigger reads as zero
    endcase
  end

  // read data register and valid strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider synchronisation trigger; self-clearing one-cycle pulse

  // pulse on a write of one to the trigger bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      divider_sync_pulse <= 1'b0;
    end else begin
      divider_sync_pulse <= wr_sync && reg_wdata[OBD_POS_SYNC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control pins

  obd_pin_sync #(
    .WIDTH(PIN_WIDTH)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_async(bank_ctl_pins),
    .pin_level(pins_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // effective settings: pins pick a preset, registers give everything
  logic [5:0] eff_int_d;
  logic [23:0] eff_frac_d;
  logic [3:0] eff_frac_int_d;
  logic [1:0] eff_post_d;
  logic eff_div_type_d;
  logic eff_src_d;
  logic eff_bank_pd_d;
  logic eff_out_pd_d;
  logic eff_style_d;
  logic [1:0] eff_swing_d;
  // pin mode keeps every other setting at its reset value
  always_comb begin
    if (cfg_src_q) begin
      eff_int_d = int_ratio_q;
      eff_frac_d = frac_q;
      eff_frac_int_d = frac_int_q;
      eff_post_d = post_div_q;
      eff_div_type_d = div_type_q;
      eff_src_d = src_sel_q;
      eff_bank_pd_d = bank_pd_q;
      eff_out_pd_d = out_pd_q;
      eff_style_d = style_q;
      eff_swing_d = swing_q;
    end else begin
      eff_int_d = pin_ratio(pins_level);
      eff_frac_d = OBD_RST_FRAC;
      eff_frac_int_d = OBD_RST_FRAC_INT;
      eff_post_d = OBD_RST_POST_DIV;
      eff_div_type_d = 1'b0;
      eff_src_d = 1'b0;
      eff_bank_pd_d = 1'b0;
      eff_out_pd_d = 1'b0;
      eff_style_d = OBD_STYLE_LVDS;
      eff_swing_d = OBD_RST_SWING;
    end
  end

  // divider settings presented to the divider
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      integer_divider_ratio <= OBD_RST_INT_RATIO;
      fraction_word <= OBD_RST_FRAC;
      fraction_integer_part <= OBD_RST_FRAC_INT;
      post_divide_factor <= 3'h1;
      fractional_ratio <= {OBD_RST_FRAC_INT, OBD_RST_FRAC};
      fractional_ratio_valid <= 1'b1;
      fractional_path_selected <= 1'b0;
      bank_driven_by_divider <= 1'b1;
      settings_from_registers <= 1'b0;
    end else begin
      integer_divider_ratio <= eff_int_d;
      fraction_word <= eff_frac_d;
      fraction_integer_part <= eff_frac_int_d;
      post_divide_factor <= post_factor(eff_post_d);
      fractional_ratio <= {eff_frac_int_d, eff_frac_d};
      fractional_ratio_valid <= (eff_frac_int_d >= OBD_FRAC_INT_MIN) &&
                                (eff_frac_int_d <= OBD_FRAC_INT_MAX) &&
                                (post_factor(eff_post_d) != 3'h0);
      fractional_path_selected <= eff_div_type_d;
      bank_driven_by_divider <= !eff_src_d;
      settings_from_registers <= cfg_src_q;
    end
  end

  // power and output format settings
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bank_active <= 1'b1;
      first_bank_output_on <= 1'b1;
      second_bank_output_oe <= 1'b1;
      output_style_lvpecl <= OBD_STYLE_LVDS;
      output_swing_mv <= OBD_MV_350;
    end else begin
      bank_active <= !eff_bank_pd_d;
      first_bank_output_on <= !(eff_bank_pd_d || eff_out_pd_d);
      second_bank_output_oe <= !(eff_bank_pd_d || eff_out_pd_d);
      output_style_lvpecl <= eff_style_d;
      output_swing_mv <= swing_mv(eff_swing_d);
    end
  end

endmodule

// ==== verification/obd_config_regs_properties.sv ====
// checker for the bank d configuration registers
// assumes it is bound onto obd_config_regs, one clock domain
`timescale 1ns/100ps
module obd_config_regs_chk
  import obd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic [23:0] fraction_word,
  input wire logic [3:0] fraction_integer_part,
  input wire logic [2:0] post_divide_factor,
  input wire logic [27:0] fractional_ratio,
  input wire logic fractional_ratio_valid,
  input wire logic fractional_path_selected,
  input wire logic bank_driven_by_divider,
  input wire logic bank_active,
  input wire logic first_bank_output_on,
  input wire logic second_bank_output_oe,
  input wire logic output_style_lvpecl,
  input wire logic [9:0] output_swing_mv,
  input wire logic settings_from_registers,
  input wire logic divider_sync_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  // register-mode write to one byte, sync request and its pulse
  sequence s_wr(a);
    reg_wr_en && reg_addr == a && settings_from_registers;
  endsequence
  sequence s_sync_req;
    reg_wr_en && reg_addr == OBD_ADDR_SYNC && reg_wdata[OBD_POS_SYNC];
  endsequence
  sequence s_pulse;
    divider_sync_pulse ##1 !divider_sync_pulse;
  endsequence
  property p_post_div;
    s_wr(OBD_ADDR_DIV_CTRL) |-> ##2 post_divide_factor == (3'h1 << $past(reg_wdata[1:0], 2));
  endproperty
  a_post_div: assert property (p_post_div) else $error("post divide factor wrong");
  property p_div_type;
    s_wr(OBD_ADDR_DIV_CTRL) |-> ##2 fractional_path_selected == $past(reg_wdata[4], 2);
  endproperty
  a_div_type: assert property (p_div_type) else $error("divider type wrong");
  property p_src;
    s_wr(OBD_ADDR_DIV_CTRL) |-> ##2 bank_driven_by_divider == !$past(reg_wdata[5], 2);
  endproperty
  a_src: assert property (p_src) else $error("bank source wrong");
  property p_bank_pd;
    !bank_active |-> !first_bank_output_on && !second_bank_output_oe;
  endproperty
  a_bank_pd: assert property (p_bank_pd) else $error("bank down but output on");
  property p_cfg;
    !settings_from_registers |-> fraction_word == OBD_RST_FRAC && post_divide_factor == 3'h1
      && bank_active && !output_style_lvpecl;
  endproperty
  a_cfg: assert property (p_cfg) else $error("pin mode shows register values");
  property p_out_pd;
    s_wr(OBD_ADDR_OUT0_CTRL) ##0 bank_active |-> ##2 second_bank_output_oe == !$past(reg_wdata[7], 2);
  endproperty
  a_out_pd: assert property (p_out_pd) else $error("output power down wrong");
  property p_style;
    s_wr(OBD_ADDR_OUT0_CTRL) |-> ##2 output_style_lvpecl == $past(reg_wdata[2], 2);
  endproperty
  a_style: assert property (p_style) else $error("output style wrong");
  property p_swing;
    s_wr(OBD_ADDR_OUT0_CTRL) |-> ##2 output_swing_mv == ($past(reg_wdata[1:0], 2) == 2'h0 ? OBD_MV_350
      : $past(reg_wdata[1:0], 2) == 2'h1 ? OBD_MV_500 : $past(reg_wdata[1:0], 2) == 2'h2 ? OBD_MV_750
      : 10'h000);
  endproperty
  a_swing: assert property (p_swing) else $error("output swing wrong");
  property p_sync;
    s_sync_req |=> s_pulse;
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse wrong");
  property p_ratio;
    fractional_ratio == {fraction_integer_part, fraction_word} && fractional_ratio_valid ==
      (fraction_integer_part >= OBD_FRAC_INT_MIN && post_divide_factor != 3'h0);
  endproperty
  a_ratio: assert property (p_ratio) else $error("fractional ratio wrong");
endmodule
bind obd_config_regs obd_config_regs_chk u_obd_config_regs_chk (.clk_sys, .reset_n, .reg_addr,
  .reg_wdata, .reg_wr_en, .fraction_word, .fraction_integer_part, .post_divide_factor,
  .fractional_ratio, .fractional_ratio_valid, .fractional_path_selected, .bank_driven_by_divider,
  .bank_active, .first_bank_output_on, .second_bank_output_oe, .output_style_lvpecl,
  .output_swing_mv, .settings_from_registers, .divider_sync_pulse);

// ==== verification/obd_host_model.sv ====
// host model driving the register port of the bank d block
// assumes requests change at the falling edge of clk_sys
`timescale 1ns/100ps
module obd_host_model
  import obd_pkg::*;
(
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr_en,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  // writable bits per byte, the rest are always sent as zero
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      OBD_ADDR_INT_RATIO: wmask = 8'h3f;
      OBD_ADDR_FRAC_INT: wmask = 8'h0f;
      OBD_ADDR_DIV_CTRL: wmask = 8'h33;
      OBD_ADDR_BANK_CTRL: wmask = 8'h81;
      OBD_ADDR_OUT0_CTRL: wmask = 8'h87;
      OBD_ADDR_OUT1_CTRL, OBD_ADDR_SYNC: wmask = 8'h80;
      8'h2f: wmask = 8'h00; // wholly reserved byte
      default: wmask = 8'hff;
    endcase
  endfunction
  // one byte write, one idle cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d & wmask(a);
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask
  // one byte read, data taken in the cycle after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    d = reg_rdata;
    v = reg_rd_valid;
  endtask
  // divider change always followed by the sync trigger
  task automatic set_div(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    wr(OBD_ADDR_SYNC, 8'h80);
  endtask
  // whole-bank power-down together with output power-down
  task automatic bank_off();
    wr(OBD_ADDR_BANK_CTRL, 8'h81);
    wr(OBD_ADDR_OUT0_CTRL, 8'h80);
  endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the bank d configuration registers
// assumes the host model on the register port and the bound checker
`timescale 1ns/100ps
module tb_top;
  import obd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n;
  logic [1:0] bank_ctl_pins;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [5:0] integer_divider_ratio;
  logic [23:0] fraction_word;
  logic [3:0] fraction_integer_part;
  logic [2:0] post_divide_factor;
  logic [27:0] fractional_ratio;
  logic fractional_ratio_valid, fractional_path_selected, bank_driven_by_divider, bank_active;
  logic first_bank_output_on, second_bank_output_oe, output_style_lvpecl;
  logic [9:0] output_swing_mv;
  logic settings_from_registers, divider_sync_pulse;
  int error_cnt = 0;
  int total_checks = 0;
  always #25 clk_sys = ~clk_sys;
  obd_config_regs #(.PIN_WIDTH(2)) u_obd_config_regs (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr_en, .reg_rd_en, .reg_rdata, .reg_rd_valid, .bank_ctl_pins, .integer_divider_ratio,
    .fraction_word, .fraction_integer_part, .post_divide_factor, .fractional_ratio,
    .fractional_ratio_valid, .fractional_path_selected, .bank_driven_by_divider, .bank_active,
    .first_bank_output_on, .second_bank_output_oe, .output_style_lvpecl, .output_swing_mv,
    .settings_from_registers, .divider_sync_pulse);
  obd_host_model u_obd_host_model (.clk_sys, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en,
    .reg_rdata, .reg_rd_valid);
  ////////////////////////////////////////////////////////////////
  // comparison, read check and expectations
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_obd_host_model.rd(a, d, v);
    chk(v, 1'b1);
    chk(d, exp);
  endtask
  function automatic logic [2:0] f_post(input logic [1:0] c);
    f_post = (c == 2'h0) ? 3'h1 : (c == 2'h1) ? 3'h2 : (c == 2'h2) ? 3'h4 : 3'h0;
  endfunction
  function automatic logic [9:0] f_mv(input logic [1:0] c);
    f_mv = (c == 2'h0) ? OBD_MV_350 : (c == 2'h1) ? OBD_MV_500 : (c == 2'h2) ? OBD_MV_750 : 10'h0;
  endfunction
  function automatic logic [5:0] f_pin(input logic [1:0] p);
    f_pin = (p == 2'h0) ? OBD_PIN_RATIO_0 : (p == 2'h1) ? OBD_PIN_RATIO_1
      : (p == 2'h2) ? OBD_PIN_RATIO_2 : OBD_PIN_RATIO_3;
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    repeat (6000) @(posedge clk_sys);
    error_cnt++;
    end_sim();
  end
  // main sequence
  initial begin
    logic [7:0] d;
    logic [3:0] fi;
    logic [23:0] fw;
    logic [1:0] pc;
    reset_n = 1'b0;
    bank_ctl_pins = 2'h0;
    void'($urandom(71546));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    chk(fractional_ratio, {OBD_RST_FRAC_INT, OBD_RST_FRAC});
    chk(output_swing_mv, OBD_MV_350);
    chk(second_bank_output_oe, 1'b1);
    rd_chk(OBD_ADDR_DIV_CTRL, 8'h00);
    rd_chk(OBD_ADDR_OUT0_CTRL, 8'h00);
    $display("test 1 done");
    for (int p = 0; p < 4; p++) begin
      @(negedge clk_sys);
      bank_ctl_pins = p[1:0];
      repeat (6) @(negedge clk_sys);
      chk(integer_divider_ratio, f_pin(p[1:0]));
    end
    u_obd_host_model.wr(OBD_ADDR_DIV_CTRL, 8'h11);
    @(negedge clk_sys);
    chk(fractional_path_selected, 1'b0);
    u_obd_host_model.wr(OBD_ADDR_BANK_CTRL, 8'h01);
    @(negedge clk_sys);
    chk(settings_from_registers, 1'b1);
    $display("test 2 done");
    for (int i = 0; i < 4; i++) begin
      d = {2'h0, 1'($urandom), 1'($urandom), 2'h0, 2'(i)};
      u_obd_host_model.set_div(OBD_ADDR_DIV_CTRL, d);
      chk(divider_sync_pulse, 1'b1);
      chk(post_divide_factor, f_post(2'(i)));
      chk(fractional_path_selected, d[4]);
      chk(bank_driven_by_divider, !d[5]);
      rd_chk(OBD_ADDR_DIV_CTRL, d);
    end
    d = 8'($urandom);
    u_obd_host_model.set_div(OBD_ADDR_INT_RATIO, d);
    bank_ctl_pins = ~bank_ctl_pins;
    repeat (6) @(negedge clk_sys);
    chk(integer_divider_ratio, d[5:0]);
    $display("test 3 done");
    for (int i = 0; i < 8; i++) begin
      d = {i[2], 4'h0, 1'($urandom), 2'(i)};
      u_obd_host_model.wr(OBD_ADDR_OUT0_CTRL, d);
      @(negedge clk_sys);
      chk(output_swing_mv, f_mv(2'(i)));
      chk(output_style_lvpecl, d[2]);
      chk(first_bank_output_on, !d[7]);
      rd_chk(OBD_ADDR_OUT1_CTRL, {d[7], 7'h00});
    end
    $display("test 4 done");
    for (int i = 0; i < 20; i++) begin
      fi = (i == 0) ? 4'h5 : (i == 1) ? 4'h4 : 4'($urandom);
      fw = 24'($urandom);
      pc = 2'($urandom);
      u_obd_host_model.wr(OBD_ADDR_FRAC_LO, fw[7:0]);
      u_obd_host_model.wr(OBD_ADDR_FRAC_MID, fw[15:8]);
      u_obd_host_model.wr(OBD_ADDR_FRAC_HI, fw[23:16]);
      u_obd_host_model.set_div(OBD_ADDR_FRAC_INT, {4'h0, fi});
      u_obd_host_model.set_div(OBD_ADDR_DIV_CTRL, {6'h04, pc});
      chk(fractional_ratio, {fi, fw});
      chk(fraction_integer_part, fi);
      chk(fractional_ratio_valid, fi >= 4'h5 && pc != 2'h3);
    end
    $display("test 5 done");
    u_obd_host_model.bank_off();
    u_obd_host_model.wr(OBD_ADDR_OUT0_CTRL, 8'h00);
    @(negedge clk_sys);
    chk(bank_active, 1'b0);
    chk(second_bank_output_oe, 1'b0);
    u_obd_host_model.wr(OBD_ADDR_BANK_CTRL, 8'h01);
    @(negedge clk_sys);
    chk(first_bank_output_on, 1'b1);
    u_obd_host_model.wr(8'h2f, 8'hff);
    rd_chk(8'h2f, 8'h00);
    rd_chk(OBD_ADDR_SYNC, 8'h00);
    u_obd_host_model.wr(OBD_ADDR_BANK_CTRL, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk(fraction_word, OBD_RST_FRAC);
    chk(integer_divider_ratio, f_pin(bank_ctl_pins));
    $display("test 6 done");
    end_sim();
  end
endmodule
